// ---- src/rmc_pkg.sv ----
// Constants and types shared by both ends of the command link.
// Assumes one 20 MHz clock and byte-wide framed transfers.
package rmc_pkg;
  // ****************************************
  // Framing
  // ****************************************
  localparam logic [7:0] STX = 8'h02;
  localparam logic [7:0] CNF_BIT = 8'h40;
  localparam logic [7:0] IND_BIT = 8'h80;
  localparam logic [7:0] RSP_BIT = 8'hC0;
  localparam logic [7:0] HDR_LEN = 8'h04;
  localparam logic [15:0] PL_MAX = 16'h0008;
  // ****************************************
  // Opcodes and payload codes
  // ****************************************
  localparam logic [7:0] OP_STATE = 8'h01;
  localparam logic [7:0] OP_CONNECT = 8'h06;
  localparam logic [7:0] OP_GET = 8'h10;
  localparam logic [7:0] OP_SET = 8'h11;
  localparam logic [7:0] OP_LAYER = 8'h1A;
  localparam logic [7:0] OP_TEST = 8'h1E;
  localparam logic [7:0] TEST_RX = 8'h01;
  localparam logic [7:0] TEST_TX = 8'h02;
  localparam logic [7:0] TEST_STOP = 8'h03;
  localparam logic [7:0] IDX_ADDR = 8'h04;
  localparam logic [7:0] IDX_CFG = 8'h1C;
  localparam logic [7:0] LR_VALUE = 8'h02;
  localparam int CFG_LR_BIT = 1;
  localparam logic [7:0] STATE_IDLE = 8'h01;
  localparam logic [7:0] STATE_DETAIL = 8'h01;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_FAIL = 8'h01;
  localparam logic [15:0] REPORT_FLAG = 16'h8000;
  localparam logic [14:0] CNT_MAX = 15'h7FFF;
  localparam logic [7:0] MAX_PAYLOAD = 8'hF3;
  localparam logic [7:0] PHY_1M = 8'h01;
  localparam logic [7:0] PHY_CODED = 8'h04;
  localparam logic [7:0] ZERO_B = 8'h00;
  // ****************************************
  // Payload lengths
  // ****************************************
  localparam logic [7:0] LEN_STATUS = 8'h01;
  localparam logic [7:0] LEN_STATE = 8'h02;
  localparam logic [7:0] LEN_TEST = 8'h03;
  localparam logic [7:0] LEN_CFG = 8'h03;
  localparam logic [7:0] LEN_ADDR = 8'h06;
  localparam logic [7:0] LEN_ADDR_CNF = 8'h07;
  localparam logic [7:0] LEN_CHAN = 8'h08;
  localparam logic [15:0] LEN_SET = 16'h0003;
  localparam logic [15:0] LEN_PEER = 16'h0006;
  // ****************************************
  // State machines
  // ****************************************
  typedef enum logic [5:0] {
    RX_START = 6'h01, RX_OP = 6'h02, RX_LEN0 = 6'h04,
    RX_LEN1 = 6'h08, RX_DATA = 6'h10, RX_CHK = 6'h20
  } rmc_rx_type;
  typedef enum logic [2:0] {
    HR_IDLE = 3'h1, HR_HEAD = 3'h2, HR_BODY = 3'h4
  } rmc_hrx_type;
endpackage : rmc_pkg

// ---- src/rmc_link_if.sv ----
// Byte link between host and radio module.
// Assumes both ends share clk; the bench joins the two modports.
interface rmc_link_if;
  logic [7:0] h2d_data;
  logic h2d_valid;
  logic [7:0] d2h_data;
  logic d2h_valid;
  logic d2h_ready;
  logic msg_pending;
  modport device (input h2d_data, input h2d_valid, input d2h_ready,
    output d2h_data, output d2h_valid, output msg_pending);
  modport host (output h2d_data, output h2d_valid, output d2h_ready,
    input d2h_data, input d2h_valid, input msg_pending);
endinterface : rmc_link_if

// ---- src/rmc_device.sv ----
// Radio module command interpreter, device end of the byte link.
// Assumes the radio core pulses rx_pkt, link_up and phy_done.
// What this block does
// R1: Receive test start answered with zero status.
// R2: Transmit stop answers zero status, flagged report.
// R3: Receive stop reports packet count below flag.
// R4: Links set up on 1M unless long-range.
// R5: Layer change ends in switched or refused indication.
// R6: Long-range flag forces long-range advertising.
// R7: Long-range flag limits scanner to long-range.
// R8: Host enables long range via setting 28.
// R9: Set confirm, restart, then idle state report.
// R10: Idle state report queued after reset.
// R11: Setting 4 read returns device address.
// R12: Connect confirm, then link indication with peer.
// R13: Channel-ready response carries peer, max payload.
// R14: Host tolerates missing layers and refusals.
// R15: Host reads four bytes, then length+1.
// R16: No new test until running one stops.
// R17: Start byte, opcode, length; reply bits 6/7.
// R18: Trailing xor check; bad frames discarded.
module rmc_device (
  rmc_link_if.device lnk,
  input wire logic clk,
  input wire logic nrst,
  input wire logic [47:0] own_addr,
  input wire logic rx_pkt,
  input wire logic link_up,
  input wire logic phy_done,
  input wire logic phy_refused,
  output logic test_rx_on,
  output logic test_tx_on,
  output logic [7:0] test_channel,
  output logic conn_start,
  output logic [47:0] conn_peer,
  output logic connected,
  output logic [7:0] phy_now,
  output logic phy_req,
  output logic [7:0] phy_target,
  output logic adv_long_range,
  output logic scan_long_range_only
);
  import rmc_pkg::*;

  // ****************************************
  // Receive parser
  // ****************************************
  rmc_rx_type rx_st_q;
  logic [7:0] rx_op_q, rx_xor_q;
  logic [15:0] rx_len_q, rx_cnt_q;
  logic [7:0] rx_pl_q [8];
  logic cmd_go, busy;

  // Frame walk, xor over every byte
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_st_q <= RX_START;
      rx_op_q <= ZERO_B;
      rx_xor_q <= ZERO_B;
      rx_len_q <= '0;
      rx_cnt_q <= '0;
      for (int i = 0; i < 8; i++) rx_pl_q[i] <= ZERO_B;
    end
    else if (lnk.h2d_valid)
    begin
      rx_xor_q <= rx_xor_q ^ lnk.h2d_data; // R18
      unique case (rx_st_q)
        RX_START:
        begin
          rx_xor_q <= lnk.h2d_data;
          if (lnk.h2d_data == STX) rx_st_q <= RX_OP; // R17
        end
        RX_OP:
        begin
          rx_op_q <= lnk.h2d_data;
          rx_st_q <= RX_LEN0;
        end
        RX_LEN0:
        begin
          rx_len_q[7:0] <= lnk.h2d_data;
          rx_st_q <= RX_LEN1;
        end
        RX_LEN1:
        begin
          rx_len_q[15:8] <= lnk.h2d_data;
          rx_cnt_q <= '0;
          rx_st_q <= ({lnk.h2d_data, rx_len_q[7:0]} == '0) ? RX_CHK : RX_DATA;
        end
        RX_DATA:
        begin
          if (rx_cnt_q < PL_MAX) rx_pl_q[rx_cnt_q[2:0]] <= lnk.h2d_data;
          rx_cnt_q <= rx_cnt_q + 16'h0001;
          if (rx_cnt_q + 16'h0001 == rx_len_q) rx_st_q <= RX_CHK;
        end
        RX_CHK: rx_st_q <= RX_START;
      endcase
    end
  end

  // Good check byte launches the command, busy ends refuse it
  assign cmd_go = lnk.h2d_valid && rx_st_q == RX_CHK && lnk.h2d_data == rx_xor_q && !busy; // R18

  function automatic logic is_op(input logic [7:0] op, input logic [7:0] want);
    is_op = op == want;
  endfunction : is_op

  // ****************************************
  // Command decode
  // ****************************************
  logic test_any, test_start_ok, test_stop_ok, set_ok, conn_ok, layer_ok;
  logic conn_wait_q, phy_busy_q, restart_q, rep_pend_q;
  logic [14:0] pkt_cnt_q;
  logic [15:0] cfg_q;

  assign test_any = test_rx_on || test_tx_on;
  assign test_start_ok = cmd_go && is_op(rx_op_q, OP_TEST) && !test_any
    && (rx_pl_q[0] == TEST_RX || rx_pl_q[0] == TEST_TX); // R16
  assign test_stop_ok = cmd_go && is_op(rx_op_q, OP_TEST) && test_any && rx_pl_q[0] == TEST_STOP;
  assign set_ok = cmd_go && is_op(rx_op_q, OP_SET) && rx_pl_q[0] == IDX_CFG && rx_len_q == LEN_SET;
  assign conn_ok = cmd_go && is_op(rx_op_q, OP_CONNECT) && !connected && !conn_wait_q && rx_len_q == LEN_PEER;
  assign layer_ok = cmd_go && is_op(rx_op_q, OP_LAYER) && connected && !phy_busy_q;
  assign busy = rep_pend_q || restart_q;

  // ****************************************
  // Confirmation builder
  // ****************************************
  logic [7:0] rep_op_q, rep_len_q;
  logic [7:0] rep_pl_q [8];
  logic rep_take, restart_go;

  // One confirmation per accepted frame of a known opcode, opcode with bit 6 set
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rep_pend_q <= 1'b0;
      rep_op_q <= ZERO_B;
      rep_len_q <= ZERO_B;
      for (int i = 0; i < 8; i++) rep_pl_q[i] <= ZERO_B;
    end
    else if (cmd_go)
    begin
      rep_pend_q <= 1'b1;
      rep_op_q <= rx_op_q | CNF_BIT; // R17
      rep_len_q <= LEN_STATUS;
      rep_pl_q[0] <= ST_FAIL;
      for (int i = 1; i < 8; i++) rep_pl_q[i] <= ZERO_B;
      if (is_op(rx_op_q, OP_TEST))
      begin
        rep_len_q <= LEN_TEST;
        if (test_start_ok) rep_pl_q[0] <= ST_OK; // R1
        if (test_stop_ok)
        begin
          rep_pl_q[0] <= ST_OK; // R2
          rep_pl_q[1] <= test_rx_on ? {1'b1, pkt_cnt_q[14:8]} : REPORT_FLAG[15:8]; // R3
          rep_pl_q[2] <= test_rx_on ? pkt_cnt_q[7:0] : REPORT_FLAG[7:0];
        end
      end
      else if (is_op(rx_op_q, OP_GET) && rx_pl_q[0] == IDX_ADDR)
      begin
        rep_len_q <= LEN_ADDR_CNF; // R11
        rep_pl_q[0] <= ST_OK;
        for (int i = 0; i < 6; i++) rep_pl_q[i + 1] <= own_addr[8 * i +: 8];
      end
      else if (is_op(rx_op_q, OP_GET) && rx_pl_q[0] == IDX_CFG)
      begin
        rep_len_q <= LEN_CFG;
        rep_pl_q[0] <= ST_OK;
        rep_pl_q[1] <= cfg_q[7:0];
        rep_pl_q[2] <= cfg_q[15:8];
      end
      else if (set_ok || conn_ok || layer_ok) rep_pl_q[0] <= ST_OK; // R9 R12
      else if (!is_op(rx_op_q, OP_GET) && !is_op(rx_op_q, OP_SET)
        && !is_op(rx_op_q, OP_CONNECT) && !is_op(rx_op_q, OP_LAYER))
        rep_pend_q <= 1'b0; // Unknown opcode dropped silently
    end
    else if (rep_take) rep_pend_q <= 1'b0;
  end

  // ****************************************
  // Test mode
  // ****************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      test_rx_on <= 1'b0;
      test_tx_on <= 1'b0;
      test_channel <= ZERO_B;
      pkt_cnt_q <= '0;
    end
    else if (restart_go || test_stop_ok)
    begin
      test_rx_on <= 1'b0;
      test_tx_on <= 1'b0;
    end
    else if (test_start_ok)
    begin
      test_rx_on <= rx_pl_q[0] == TEST_RX;
      test_tx_on <= rx_pl_q[0] == TEST_TX;
      test_channel <= rx_pl_q[1];
      pkt_cnt_q <= '0;
    end
    else if (test_rx_on && rx_pkt && pkt_cnt_q != CNT_MAX) pkt_cnt_q <= pkt_cnt_q + 15'h0001; // R3
  end

  // ****************************************
  // Connection and layer
  // ****************************************
  logic pi_stat_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      connected <= 1'b0;
      conn_wait_q <= 1'b0;
      conn_start <= 1'b0;
      conn_peer <= '0;
      phy_now <= PHY_1M;
      phy_busy_q <= 1'b0;
      phy_req <= 1'b0;
      phy_target <= ZERO_B;
      pi_stat_q <= 1'b0;
    end
    else
    begin
      conn_start <= conn_ok;
      phy_req <= layer_ok;
      if (restart_go)
      begin
        connected <= 1'b0;
        conn_wait_q <= 1'b0;
        phy_busy_q <= 1'b0;
        phy_now <= PHY_1M;
      end
      else
      begin
        if (conn_ok)
        begin
          conn_wait_q <= 1'b1;
          for (int i = 0; i < 6; i++) conn_peer[8 * i +: 8] <= rx_pl_q[i];
        end
        if (conn_wait_q && link_up)
        begin
          conn_wait_q <= 1'b0;
          connected <= 1'b1;
          phy_now <= cfg_q[CFG_LR_BIT] ? PHY_CODED : PHY_1M; // R4
        end
        if (layer_ok)
        begin
          phy_busy_q <= 1'b1; // R5
          phy_target <= rx_pl_q[0];
        end
        if (phy_busy_q && phy_done)
        begin
          phy_busy_q <= 1'b0;
          pi_stat_q <= phy_refused; // R5
          if (!phy_refused) phy_now <= phy_target;
        end
      end
    end
  end

  assign adv_long_range = cfg_q[CFG_LR_BIT]; // R6
  assign scan_long_range_only = cfg_q[CFG_LR_BIT]; // R7

  // ****************************************
  // Queued events and settings
  // ****************************************
  logic st_pend_q, ci_pend_q, ch_pend_q, pi_pend_q;
  logic [4:0] grant;

  // Set wins over the clear of a flag being sent
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_pend_q <= 1'b1; // R10
      ci_pend_q <= 1'b0;
      ch_pend_q <= 1'b0;
      pi_pend_q <= 1'b0;
      restart_q <= 1'b0;
      cfg_q <= '0;
    end
    else
    begin
      if (grant[1]) st_pend_q <= 1'b0;
      if (grant[2]) ci_pend_q <= 1'b0;
      if (grant[3]) ch_pend_q <= 1'b0;
      if (grant[4]) pi_pend_q <= 1'b0;
      if (set_ok)
      begin
        cfg_q <= {rx_pl_q[2], rx_pl_q[1]};
        restart_q <= 1'b1;
      end
      if (restart_go)
      begin
        restart_q <= 1'b0;
        st_pend_q <= 1'b1; // R9
        ci_pend_q <= 1'b0;
        ch_pend_q <= 1'b0;
        pi_pend_q <= 1'b0;
      end
      else
      begin
        if (conn_wait_q && link_up)
        begin
          ci_pend_q <= 1'b1; // R12
          ch_pend_q <= 1'b1; // R13
        end
        if (phy_busy_q && phy_done) pi_pend_q <= 1'b1; // R5
      end
    end
  end

  // ****************************************
  // Frame transmitter
  // ****************************************
  logic tx_busy_q;
  logic [7:0] tx_idx_q, tx_xor_q, out_q, fr_op_q, fr_len_q;
  logic [7:0] fr_pl_q [8];
  logic [7:0] s_op, s_len, nx_xor, nx_idx;
  logic [7:0] s_pl [8];
  logic tx_ld, fire, tx_last;

  // Next frame by priority: confirm, state, link, channel, layer
  always_comb
  begin
    grant = '0;
    s_op = ZERO_B;
    s_len = ZERO_B;
    for (int i = 0; i < 8; i++) s_pl[i] = ZERO_B;
    if (rep_pend_q)
    begin
      grant[0] = 1'b1;
      s_op = rep_op_q;
      s_len = rep_len_q;
      for (int i = 0; i < 8; i++) s_pl[i] = rep_pl_q[i];
    end
    else if (st_pend_q && !restart_q)
    begin
      grant[1] = 1'b1;
      s_op = OP_STATE | CNF_BIT; // R10
      s_len = LEN_STATE;
      s_pl[0] = STATE_IDLE;
      s_pl[1] = STATE_DETAIL;
    end
    else if (ci_pend_q || ch_pend_q)
    begin
      grant[2] = ci_pend_q;
      grant[3] = !ci_pend_q;
      s_op = OP_CONNECT | (ci_pend_q ? IND_BIT : RSP_BIT); // R17
      s_len = ci_pend_q ? LEN_ADDR_CNF : LEN_CHAN;
      s_pl[0] = ST_OK;
      for (int i = 0; i < 6; i++) s_pl[i + 1] = conn_peer[8 * i +: 8]; // R12
      if (!ci_pend_q) s_pl[7] = MAX_PAYLOAD; // R13
    end
    else if (pi_pend_q)
    begin
      grant[4] = 1'b1;
      s_op = OP_LAYER | IND_BIT; // R5
      s_len = LEN_STATE;
      s_pl[0] = pi_stat_q ? ST_FAIL : ST_OK;
      s_pl[1] = phy_now;
    end
    if (tx_busy_q) grant = '0;
  end

  function automatic logic [7:0] byte_at(input logic [7:0] i, input logic [7:0] op,
    input logic [7:0] len, input logic [7:0] pl [8]);
    logic [7:0] k;
    k = i - HDR_LEN;
    if (i == 8'h01) byte_at = op;
    else if (i == 8'h02) byte_at = len;
    else if (i == 8'h03) byte_at = ZERO_B;
    else byte_at = pl[k[2:0]];
  endfunction : byte_at

  assign tx_ld = !tx_busy_q && grant != '0;
  assign rep_take = grant[0];
  assign fire = tx_busy_q && lnk.d2h_ready;
  assign tx_last = fire && tx_idx_q == HDR_LEN + fr_len_q;
  assign restart_go = tx_last && restart_q && fr_op_q == (OP_SET | CNF_BIT); // R9
  assign nx_xor = tx_xor_q ^ out_q;
  assign nx_idx = tx_idx_q + 8'h01;

  // Streams start, header, payload, then running xor
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_busy_q <= 1'b0;
      tx_idx_q <= ZERO_B;
      tx_xor_q <= ZERO_B;
      out_q <= ZERO_B;
      fr_op_q <= ZERO_B;
      fr_len_q <= ZERO_B;
      for (int i = 0; i < 8; i++) fr_pl_q[i] <= ZERO_B;
    end
    else if (tx_ld)
    begin
      tx_busy_q <= 1'b1;
      tx_idx_q <= ZERO_B;
      tx_xor_q <= ZERO_B;
      out_q <= STX; // R17
      fr_op_q <= s_op;
      fr_len_q <= s_len;
      for (int i = 0; i < 8; i++) fr_pl_q[i] <= s_pl[i];
    end
    else if (fire)
    begin
      tx_idx_q <= nx_idx;
      tx_xor_q <= nx_xor;
      if (tx_last) tx_busy_q <= 1'b0;
      else if (nx_idx == HDR_LEN + fr_len_q) out_q <= nx_xor; // R18
      else out_q <= byte_at(nx_idx, fr_op_q, fr_len_q, fr_pl_q);
    end
  end

  assign lnk.d2h_data = out_q;
  assign lnk.d2h_valid = tx_busy_q;
  assign lnk.msg_pending = tx_busy_q;
endmodule : rmc_device

// ---- src/rmc_host.sv ----
// Host end: frames user commands and fetches module messages.
// Assumes the device end sits on the other modport, same clk.
module rmc_host (
  rmc_link_if.host lnk,
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_op,
  input wire logic [7:0] cmd_len,
  input wire logic [63:0] cmd_data,
  input wire logic lr_enable,
  output logic rsp_valid,
  output logic rsp_ok,
  output logic [7:0] rsp_op,
  output logic [15:0] rsp_len,
  output logic [63:0] rsp_data,
  output logic layer_refused
);
  import rmc_pkg::*;

  // ****************************************
  // Command sender
  // ****************************************
  logic busy_q;
  logic [7:0] idx_q, xor_q, out_q, op_q, len_q, nx_idx, nx_xor;
  logic [63:0] pl_q;

  assign cmd_ready = !busy_q && !lr_enable;
  assign nx_idx = idx_q + 8'h01;
  assign nx_xor = xor_q ^ out_q;

  // One byte a cycle, check byte last
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_q <= 1'b0;
      idx_q <= ZERO_B;
      xor_q <= ZERO_B;
      out_q <= ZERO_B;
      op_q <= ZERO_B;
      len_q <= ZERO_B;
      pl_q <= '0;
    end
    else if (!busy_q && (lr_enable || cmd_valid))
    begin
      busy_q <= 1'b1;
      idx_q <= ZERO_B;
      xor_q <= ZERO_B;
      out_q <= STX; // R17
      op_q <= lr_enable ? OP_SET : cmd_op;
      len_q <= lr_enable ? LEN_SET[7:0] : cmd_len;
      pl_q <= lr_enable ? {40'h0, ZERO_B, LR_VALUE, IDX_CFG} : cmd_data; // R8
    end
    else if (busy_q)
    begin
      idx_q <= nx_idx;
      xor_q <= nx_xor;
      if (idx_q == HDR_LEN + len_q) busy_q <= 1'b0;
      else if (nx_idx == HDR_LEN + len_q) out_q <= nx_xor; // R18
      else if (nx_idx == 8'h01) out_q <= op_q;
      else if (nx_idx == 8'h02) out_q <= len_q;
      else if (nx_idx == 8'h03) out_q <= ZERO_B;
      else out_q <= pl_q[8 * (nx_idx - HDR_LEN) +: 8];
    end
  end

  assign lnk.h2d_data = out_q;
  assign lnk.h2d_valid = busy_q;

  // ****************************************
  // Message fetch
  // ****************************************
  rmc_hrx_type st_q;
  logic [15:0] cnt_q, rem_q;
  logic [7:0] rx_xor_q;
  logic take, last_body;

  assign lnk.d2h_ready = st_q != HR_IDLE;
  assign take = lnk.d2h_ready && lnk.d2h_valid;
  assign last_body = st_q == HR_BODY && cnt_q == rem_q;

  // Four header bytes, then length plus one more
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= HR_IDLE;
      cnt_q <= '0;
      rem_q <= '0;
      rx_xor_q <= ZERO_B;
      rsp_valid <= 1'b0;
      rsp_ok <= 1'b0;
      rsp_op <= ZERO_B;
      rsp_len <= '0;
      rsp_data <= '0;
      layer_refused <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      layer_refused <= 1'b0;
      unique case (st_q)
        HR_IDLE:
        begin
          cnt_q <= '0;
          rx_xor_q <= ZERO_B;
          if (lnk.msg_pending) st_q <= HR_HEAD; // R15
        end
        HR_HEAD:
          if (take)
          begin
            rx_xor_q <= rx_xor_q ^ lnk.d2h_data;
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == 16'h0001) rsp_op <= lnk.d2h_data;
            if (cnt_q == 16'h0002) rsp_len[7:0] <= lnk.d2h_data;
            if (cnt_q == 16'h0003)
            begin
              rsp_len[15:8] <= lnk.d2h_data;
              rem_q <= {lnk.d2h_data, rsp_len[7:0]}; // R15
              cnt_q <= '0;
              rsp_data <= '0;
              st_q <= HR_BODY;
            end
          end
        HR_BODY:
          if (take)
          begin
            rx_xor_q <= rx_xor_q ^ lnk.d2h_data;
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q < PL_MAX && !last_body) rsp_data[8 * cnt_q[2:0] +: 8] <= lnk.d2h_data;
            if (last_body)
            begin
              st_q <= HR_IDLE;
              rsp_valid <= 1'b1;
              rsp_ok <= lnk.d2h_data == rx_xor_q; // R18
              layer_refused <= rsp_op == (OP_LAYER | IND_BIT) && rsp_data[7:0] != ST_OK; // R14
            end
          end
      endcase
    end
  end
endmodule : rmc_host

// ---- testbench/rmc_link_checker.sv ----
// Concurrent checks on the host-device byte link.
// Assumes the bench instantiates it beside the link interface.
module rmc_link_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] h2d_data,
  input wire logic h2d_valid,
  input wire logic [7:0] d2h_data,
  input wire logic d2h_valid,
  input wire logic d2h_ready,
  input wire logic msg_pending
);
  import rmc_pkg::*;
  logic take;
  logic [7:0] h_acc_q;
  logic [7:0] d_acc_q;
  logic [7:0] d_len_q;
  logic [3:0] h_cnt_q;
  logic [3:0] d_cnt_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  assign take = d2h_valid && d2h_ready;
  // Running xor and index of host bytes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      h_acc_q <= 8'h00;
      h_cnt_q <= 4'h0;
    end
    else if (h2d_valid)
    begin
      h_acc_q <= (h_cnt_q == 4'h0 ? 8'h00 : h_acc_q) ^ h2d_data;
      h_cnt_q <= h_cnt_q + 4'h1;
    end
    else
      h_cnt_q <= 4'h0;
  end
  // Running xor, index and length of device bytes taken
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      d_acc_q <= 8'h00;
      d_cnt_q <= 4'h0;
      d_len_q <= 8'h00;
    end
    else if (!d2h_valid)
      d_cnt_q <= 4'h0;
    else if (take)
    begin
      d_acc_q <= (d_cnt_q == 4'h0 ? 8'h00 : d_acc_q) ^ d2h_data;
      d_cnt_q <= d_cnt_q + 4'h1;
      if (d_cnt_q == 4'h2)
        d_len_q <= d2h_data;
    end
  end
  // ****************************************
  // Link assertions
  // ****************************************
  a_pending_mirrors_valid: assert property (msg_pending == d2h_valid) else $error("pending flag differs");
  a_reply_data_holds: assert property (d2h_valid && !d2h_ready |=> $stable(d2h_data)) else $error("byte moved");
  a_reset_report_loads: assert property ($rose(nrst) |=> d2h_valid) else $error("no report after reset");
  a_reply_start_byte: assert property ($rose(d2h_valid) |-> d2h_data == STX) else $error("bad reply start");
  a_host_start_byte: assert property ($rose(h2d_valid) |-> h2d_data == STX) else $error("bad request start");
  a_host_opcode_plain: assert property (h2d_valid && h_cnt_q == 4'h1 |-> h2d_data[7:6] == 2'b00)
    else $error("request opcode marked");
  a_reply_opcode_marked: assert property (take && d_cnt_q == 4'h1 |-> d2h_data[7:6] != 2'b00)
    else $error("reply opcode unmarked");
  a_reply_len_high: assert property (take && d_cnt_q == 4'h3 |-> d2h_data == ZERO_B) else $error("len high");
  a_host_check_byte: assert property ((h2d_valid && h_cnt_q != 4'h0) ##1 !h2d_valid
    |-> $past(h2d_data) == $past(h_acc_q)) else $error("request check byte");
  a_reply_check_byte: assert property (take ##1 !d2h_valid |-> $past(d2h_data) == $past(d_acc_q))
    else $error("reply check byte");
  a_reply_frame_len: assert property (take ##1 !d2h_valid
    |-> {4'h0, $past(d_cnt_q)} == $past(d_len_q) + 8'h04) else $error("reply length");
endmodule : rmc_link_checker

// ---- testbench/radio_module_command_frames_tb.sv ----
// Bench joining host and device ends over the byte link.
// Assumes package, interface, both ends and the checker are compiled.
module radio_module_command_frames_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rmc_pkg::*;
  logic clk, nrst, cmd_valid, cmd_ready, lr_enable, rsp_valid, rsp_ok, layer_refused, got_ref;
  logic rx_pkt, link_up, phy_done, phy_refused, test_rx_on, test_tx_on, connected, adv_lr, scan_lr;
  logic [7:0] cmd_op, cmd_len, rsp_op, phy_now, phy_target;
  logic [63:0] cmd_data, rsp_data;
  logic [47:0] own_addr, conn_peer;
  logic [15:0] rsp_len;
  int fails, checks, cycles;
  rmc_link_if lnk ();
  rmc_host u_rmc_host (.lnk(lnk.host), .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_len(cmd_len), .cmd_data(cmd_data), .lr_enable(lr_enable), .rsp_valid(rsp_valid),
    .rsp_ok(rsp_ok), .rsp_op(rsp_op), .rsp_len(rsp_len), .rsp_data(rsp_data), .layer_refused(layer_refused));
  rmc_device u_rmc_device (.lnk(lnk.device), .clk(clk), .nrst(nrst), .own_addr(own_addr), .rx_pkt(rx_pkt),
    .link_up(link_up), .phy_done(phy_done), .phy_refused(phy_refused), .test_rx_on(test_rx_on),
    .test_tx_on(test_tx_on), .test_channel(), .conn_start(), .conn_peer(conn_peer), .connected(connected),
    .phy_now(phy_now), .phy_req(), .phy_target(phy_target), .adv_long_range(adv_lr), .scan_long_range_only(scan_lr));
  rmc_link_checker u_rmc_link_checker (.clk(clk), .nrst(nrst), .h2d_data(lnk.h2d_data),
    .h2d_valid(lnk.h2d_valid), .d2h_data(lnk.d2h_data), .d2h_valid(lnk.d2h_valid),
    .d2h_ready(lnk.d2h_ready), .msg_pending(lnk.msg_pending));
  // ****************************************
  // Tasks
  // ****************************************
  task check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task give_verdict;
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  task send(input logic [7:0] op, input logic [7:0] len, input logic [63:0] d);
    while (cmd_ready !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_len <= len;
    cmd_data <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask : send
  task fetch(input logic [7:0] op, input logic [63:0] mask, input logic [63:0] exp);
    while (rsp_valid !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    check({rsp_ok, rsp_op}, {1'b1, op});
    check(rsp_data & mask, exp);
    got_ref = layer_refused;
    @(posedge clk);
    #1;
  endtask : fetch
  task pulse(input int which);
    @(posedge clk);
    if (which == 0) rx_pkt <= 1'b1;
    else if (which == 1) link_up <= 1'b1;
    else {phy_done, phy_refused} <= 2'h3;
    @(posedge clk);
    {rx_pkt, link_up, phy_done} <= 3'h0;
  endtask : pulse
  // ****************************************
  // Clock, timeout and sequence
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      give_verdict;
    end
  end
  initial
  begin
    {nrst, cmd_valid, lr_enable, rx_pkt, link_up, phy_done, phy_refused} = 7'h00;
    {cmd_op, cmd_len, cmd_data} = 80'h0;
    own_addr = 48'h0018DA000055;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    fetch(8'h41, 64'hFFFF, 64'h0101);
    check({adv_lr, scan_lr}, 2'b00);
    send(OP_GET, 8'h01, {56'h0, IDX_ADDR});
    fetch(8'h50, 64'h00FFFFFFFFFFFFFF, {8'h00, own_addr, ST_OK});
    check(rsp_len, 16'h0007);
    send(OP_TEST, 8'h04, {56'h0, TEST_RX});
    fetch(8'h5E, 64'hFFFFFF, 64'h0);
    check(test_rx_on, 1'b1);
    send(OP_TEST, 8'h04, {56'h0, TEST_TX});
    fetch(8'h5E, 64'hFF, {56'h0, ST_FAIL});
    repeat (3) pulse(0);
    send(OP_TEST, 8'h04, {56'h0, TEST_STOP});
    fetch(8'h5E, 64'hFFFFFF, 64'h038000);
    send(OP_TEST, 8'h04, {56'h0, TEST_TX});
    fetch(8'h5E, 64'hFF, 64'h0);
    check(test_tx_on, 1'b1);
    send(OP_TEST, 8'h04, {56'h0, TEST_STOP});
    fetch(8'h5E, 64'hFFFFFF, 64'h008000);
    check(test_tx_on, 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      send(OP_CONNECT, 8'h06, 64'h00000018DA000011);
      fetch(8'h46, 64'hFF, 64'h0);
      check(conn_peer, 48'h0018DA000011);
      pulse(1);
      fetch(8'h86, 64'h00FFFFFFFFFFFFFF, 64'h0018DA00001100);
      fetch(8'hC6, '1, {MAX_PAYLOAD, 48'h0018DA000011, ST_OK});
      check({connected, phy_now}, {1'b1, i == 0 ? PHY_1M : PHY_CODED});
      if (i == 0)
      begin
        send(OP_LAYER, 8'h01, {56'h0, PHY_CODED});
        fetch(8'h5A, 64'hFF, 64'h0);
        check(phy_target, PHY_CODED);
        pulse(2);
        fetch(8'h9A, 64'hFFFF, 64'h0101);
        check(got_ref, 1'b1);
        @(posedge clk);
        lr_enable <= 1'b1;
        @(posedge clk);
        lr_enable <= 1'b0;
        fetch(8'h51, 64'hFF, 64'h0);
        fetch(8'h41, 64'hFFFF, 64'h0101);
        check({adv_lr, scan_lr}, 2'b11);
      end
    end
    give_verdict;
  end
endmodule : radio_module_command_frames_tb
